// ===== event_source_model.sv
// Purpose: Peripheral event sources that sit beside the interrupt bank
// Assumes: Events are one-cycle pulses launched just after a rising edge
// Notes: Driven by task calls from the bench
`timescale 1ns/1ps
module event_source_model (
  input wire logic clk_sys,
  output logic timer0_overflow,
  output logic [4:0] port_change_flags,
  output logic ext_pin_in,
  output logic osc_fail_event,
  output logic clock_switch_ready,
  output logic converter_done
);
  // Quiet sources at time zero
  initial begin
    {timer0_overflow, osc_fail_event, clock_switch_ready, converter_done} = 4'h0;
    port_change_flags = 5'h00;
    ext_pin_in = 1'b0;
  end

  // One-cycle pulses; sel bits are timer0, osc fail, clock switch, converter
  task automatic pulse(input logic [3:0] sel);
    @(posedge clk_sys);
    timer0_overflow <= sel[0];
    osc_fail_event <= sel[1];
    clock_switch_ready <= sel[2];
    converter_done <= sel[3];
    @(posedge clk_sys);
    {timer0_overflow, osc_fail_event, clock_switch_ready, converter_done} <= 4'h0;
  endtask : pulse

  // Routed pin level
  task automatic pin(input logic v);
    @(posedge clk_sys);
    ext_pin_in <= v;
  endtask : pin

  // Port change flags are levels that software clears at their source
  task automatic set_ports(input logic [4:0] v);
    @(posedge clk_sys);
    port_change_flags <= v;
  endtask : set_ports
endmodule : event_source_model

// ===== irq_bank_defines.svh
// Purpose: Offsets, field positions, masks and reset values of the interrupt bank
// Assumes: Byte wide registers on a plain strobe port with a 4 bit address
// Notes: The bank's numbers are named here once, apart from the read mux zero padding, the wdata[5] of a cover and the bit indices of some assertions
`ifndef IRQ_BANK_DEFINES_SVH
`define IRQ_BANK_DEFINES_SVH

// Register offsets
`define OFS_TIMER_EN 4'h0
`define OFS_LOGIC_CELL_EN 4'h1
`define OFS_CAPCOMP_EN 4'h2
`define OFS_MISC_EN 4'h3
`define OFS_CORE_FLAGS 4'h4
`define OFS_CLOCK_ADC_FLAGS 4'h5
`define OFS_IRQ_CTRL 4'h6
`define OFS_EVT_STATUS 4'h7
`define OFS_EVT_MASK 4'h8

// Implemented bits of each enable register
`define MASK_TIMER_EN 8'h03
`define MASK_LOGIC_CELL_EN 8'hf1
`define MASK_CAPCOMP_EN 8'h03
`define MASK_MISC_EN 8'h31

// Field positions
`define BIT_TIMER2_MATCH 1
`define BIT_TIMER1_OVF 0
`define BIT_TIMER0_OVF_FLAG 5
`define BIT_PIN_CHANGE_FLAG 4
`define BIT_EXT_PIN_FLAG 0
`define BIT_OSC_FAIL_FLAG 7
`define BIT_CLOCK_SWITCH_FLAG 6
`define BIT_CONVERTER_FLAG 0
`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_EN 6

// Event status layout
`define EVT_WIDTH 6
`define MASK_EVT 8'h3f

// Reset values
`define RST_BYTE 8'h00
`define RST_EVT 6'h00

`endif

// ===== irq_bank_pkg.sv
// Purpose: Shared types of the interrupt bank
// Assumes: Constants live in irq_bank_defines.svh
// Notes: Types only
package irq_bank_pkg;
  typedef logic [3:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;
endpackage : irq_bank_pkg

// ===== periph_irq_bank.sv
// Purpose: Upper peripheral interrupt enables, first two flag registers, core request
// Assumes: Event inputs are one-cycle pulses synchronous to clk_sys
// Notes: Register read data appears the cycle after the read strobe
//
// Summary of operation
// (RQ1) Upper enables need the peripheral group enable
// (RQ2) Unimplemented bits read zero, ignore writes
// (RQ3) Timer enables: bit1 timer2 match, bit0 timer1
// (RQ4) Logic cells 4..1 in bits 7..4, gate bit0
// (RQ5) Capture/compare enables: bit1 unit two, bit0 one
// (RQ6) Misc: memory task, rollover bit4, waveform bit0
// (RQ7) Timer0 overflow sets bit5, software clears
// (RQ8) Bit4 read-only OR of port change flags
// (RQ9) Selected pin edge sets bit0, software clears
// (RQ10) Oscillator failure sets bit7 until cleared
// (RQ11) Clock switch ready sets bit6
// (RQ12) Conversion complete sets bit0
// (RQ13) All bits reset to zero on any reset; core flag bit4 still follows the port change flags
// (RQ14) Nothing reaches core without global enable; the irq output is not gated by it
// (RQ15) Lowest-register sources need only global enable
// (RQ16) Request needs flag and enable; writing one sets
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "irq_bank_defines.svh"
module periph_irq_bank #(
  parameter int PORT_COUNT = 5
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire irq_bank_pkg::reg_addr_t addr,
  input wire irq_bank_pkg::reg_byte_t wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output irq_bank_pkg::reg_byte_t rdata,
  input wire logic timer0_overflow,
  input wire logic [PORT_COUNT-1:0] port_change_flags,
  input wire logic ext_pin_in,
  input wire logic ext_pin_rising_sel,
  input wire logic osc_fail_event,
  input wire logic clock_switch_ready,
  input wire logic converter_done,
  input wire logic timer0_irq_en,
  input wire logic pin_change_irq_en,
  input wire logic ext_pin_irq_en,
  input wire logic osc_fail_irq_en,
  input wire logic clock_switch_irq_en,
  input wire logic converter_irq_en,
  input wire irq_bank_pkg::reg_byte_t timer_flags_in,
  input wire irq_bank_pkg::reg_byte_t logic_cell_flags_in,
  input wire irq_bank_pkg::reg_byte_t capcomp_flags_in,
  input wire irq_bank_pkg::reg_byte_t misc_flags_in,
  output logic core_irq_req,
  output logic irq
);

  // Address match of a strobe
  function automatic logic hit(input logic strobe, input irq_bank_pkg::reg_addr_t a,
                               input irq_bank_pkg::reg_addr_t ofs);
    hit = strobe && (a == ofs);
  endfunction : hit

  irq_bank_pkg::reg_byte_t timer_irq_enable_r;
  irq_bank_pkg::reg_byte_t logic_cell_irq_enable_r;
  irq_bank_pkg::reg_byte_t capture_compare_irq_enable_r;
  irq_bank_pkg::reg_byte_t misc_irq_enable_r;
  logic global_irq_en_r;
  logic periph_group_irq_en_r;
  logic [`EVT_WIDTH-1:0] evt_status_r;
  logic [`EVT_WIDTH-1:0] evt_status_nxt;
  logic [`EVT_WIDTH-1:0] evt_mask_r;
  logic [`EVT_WIDTH-1:0] evt_set;
  logic ext_pin_prev_r;
  logic ext_edge;
  logic timer0_overflow_flag;
  logic ext_pin_flag;
  logic osc_fail_flag;
  logic clock_switch_flag;
  logic converter_done_flag;
  logic pin_change_summary_flag;
  logic wr_core;
  logic wr_clk_adc;
  logic low_req;
  logic mid_req;
  logic upper_req;
  logic core_irq_prev_r;
  irq_bank_pkg::reg_byte_t core_irq_flags;
  irq_bank_pkg::reg_byte_t clock_adc_irq_flags;
  irq_bank_pkg::reg_byte_t rdata_nxt;

  // Enable registers keep only implemented bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_irq_enable_r <= `RST_BYTE; // RQ13
      logic_cell_irq_enable_r <= `RST_BYTE;
      capture_compare_irq_enable_r <= `RST_BYTE;
      misc_irq_enable_r <= `RST_BYTE;
    end else begin
      if (hit(wr_en, addr, `OFS_TIMER_EN)) begin
        timer_irq_enable_r <= wdata & `MASK_TIMER_EN; // RQ3 RQ2
      end
      if (hit(wr_en, addr, `OFS_LOGIC_CELL_EN)) begin
        logic_cell_irq_enable_r <= wdata & `MASK_LOGIC_CELL_EN; // RQ4 RQ2
      end
      if (hit(wr_en, addr, `OFS_CAPCOMP_EN)) begin
        capture_compare_irq_enable_r <= wdata & `MASK_CAPCOMP_EN; // RQ5 RQ2
      end
      if (hit(wr_en, addr, `OFS_MISC_EN)) begin
        misc_irq_enable_r <= wdata & `MASK_MISC_EN; // RQ6 RQ2
      end
    end
  end

  // Global and peripheral group enables
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      global_irq_en_r <= 1'b0; // RQ13
      periph_group_irq_en_r <= 1'b0;
    end else if (hit(wr_en, addr, `OFS_IRQ_CTRL)) begin
      global_irq_en_r <= wdata[`BIT_GLOBAL_EN];
      periph_group_irq_en_r <= wdata[`BIT_PERIPH_EN];
    end
  end

  // External pin edge detector, polarity chosen by ext_pin_rising_sel
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_pin_prev_r <= 1'b0;
    end else begin
      ext_pin_prev_r <= ext_pin_in;
    end
  end

  assign ext_edge = ext_pin_rising_sel ? (ext_pin_in && !ext_pin_prev_r)
                                       : (!ext_pin_in && ext_pin_prev_r); // RQ9

  assign wr_core = hit(wr_en, addr, `OFS_CORE_FLAGS);
  assign wr_clk_adc = hit(wr_en, addr, `OFS_CLOCK_ADC_FLAGS);

  // Hardware-set flags of the first flag register
  sticky_flag_cell u_timer0_flag (
    .clk_sys(clk_sys),
    .rst(rst),
    .hw_set(timer0_overflow), // RQ7
    .sw_wr(wr_core),
    .sw_val(wdata[`BIT_TIMER0_OVF_FLAG]),
    .flag(timer0_overflow_flag)
  );

  sticky_flag_cell u_ext_pin_flag (
    .clk_sys(clk_sys),
    .rst(rst),
    .hw_set(ext_edge), // RQ9
    .sw_wr(wr_core),
    .sw_val(wdata[`BIT_EXT_PIN_FLAG]),
    .flag(ext_pin_flag)
  );

  // Hardware-set flags of the second flag register
  sticky_flag_cell u_osc_fail_flag (
    .clk_sys(clk_sys),
    .rst(rst),
    .hw_set(osc_fail_event), // RQ10
    .sw_wr(wr_clk_adc),
    .sw_val(wdata[`BIT_OSC_FAIL_FLAG]),
    .flag(osc_fail_flag)
  );

  sticky_flag_cell u_clock_switch_flag (
    .clk_sys(clk_sys),
    .rst(rst),
    .hw_set(clock_switch_ready), // RQ11
    .sw_wr(wr_clk_adc),
    .sw_val(wdata[`BIT_CLOCK_SWITCH_FLAG]),
    .flag(clock_switch_flag)
  );

  sticky_flag_cell u_converter_flag (
    .clk_sys(clk_sys),
    .rst(rst),
    .hw_set(converter_done), // RQ12
    .sw_wr(wr_clk_adc),
    .sw_val(wdata[`BIT_CONVERTER_FLAG]),
    .flag(converter_done_flag)
  );

  // Summary flag follows the port flags; writes cannot touch it
  assign pin_change_summary_flag = |port_change_flags; // RQ8

  // Readable images of the flag registers, unimplemented bits zero
  always_comb begin
    core_irq_flags = `RST_BYTE; // RQ2
    core_irq_flags[`BIT_TIMER0_OVF_FLAG] = timer0_overflow_flag;
    core_irq_flags[`BIT_PIN_CHANGE_FLAG] = pin_change_summary_flag;
    core_irq_flags[`BIT_EXT_PIN_FLAG] = ext_pin_flag;
    clock_adc_irq_flags = `RST_BYTE;
    clock_adc_irq_flags[`BIT_OSC_FAIL_FLAG] = osc_fail_flag;
    clock_adc_irq_flags[`BIT_CLOCK_SWITCH_FLAG] = clock_switch_flag;
    clock_adc_irq_flags[`BIT_CONVERTER_FLAG] = converter_done_flag;
  end

  // Request toward the core: flag and enable per source, then group gates
  assign low_req = (timer0_overflow_flag && timer0_irq_en) ||
                   (pin_change_summary_flag && pin_change_irq_en) ||
                   (ext_pin_flag && ext_pin_irq_en); // RQ16 RQ15
  assign mid_req = (osc_fail_flag && osc_fail_irq_en) ||
                   (clock_switch_flag && clock_switch_irq_en) ||
                   (converter_done_flag && converter_irq_en); // RQ16
  assign upper_req = |(timer_irq_enable_r & timer_flags_in) ||
                     |(logic_cell_irq_enable_r & logic_cell_flags_in) ||
                     |(capture_compare_irq_enable_r & capcomp_flags_in) ||
                     |(misc_irq_enable_r & misc_flags_in); // RQ3 RQ4 RQ5 RQ6
  assign core_irq_req = global_irq_en_r &&
                        (low_req || (periph_group_irq_en_r && (mid_req || upper_req))); // RQ14 RQ1

  // Rising edge of the core request is one of the status events
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      core_irq_prev_r <= 1'b0;
    end else begin
      core_irq_prev_r <= core_irq_req;
    end
  end

  assign evt_set = {core_irq_req && !core_irq_prev_r, converter_done, clock_switch_ready,
                    osc_fail_event, ext_edge, timer0_overflow};

  // Sticky status, cleared by reading it; a new event wins over the clear
  always_comb begin
    evt_status_nxt = evt_status_r;
    if (hit(rd_en, addr, `OFS_EVT_STATUS)) begin
      evt_status_nxt = `RST_EVT;
    end
    evt_status_nxt = evt_status_nxt | evt_set;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evt_status_r <= `RST_EVT;
    end else begin
      evt_status_r <= evt_status_nxt;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evt_mask_r <= `RST_EVT;
    end else if (hit(wr_en, addr, `OFS_EVT_MASK)) begin
      evt_mask_r <= wdata[`EVT_WIDTH-1:0];
    end
  end

  assign irq = |(evt_status_r & evt_mask_r);

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (addr)
      `OFS_TIMER_EN: rdata_nxt = timer_irq_enable_r;
      `OFS_LOGIC_CELL_EN: rdata_nxt = logic_cell_irq_enable_r;
      `OFS_CAPCOMP_EN: rdata_nxt = capture_compare_irq_enable_r;
      `OFS_MISC_EN: rdata_nxt = misc_irq_enable_r;
      `OFS_CORE_FLAGS: rdata_nxt = core_irq_flags;
      `OFS_CLOCK_ADC_FLAGS: rdata_nxt = clock_adc_irq_flags;
      `OFS_IRQ_CTRL: rdata_nxt = {global_irq_en_r, periph_group_irq_en_r, 6'h00};
      `OFS_EVT_STATUS: rdata_nxt = {2'h0, evt_status_r};
      `OFS_EVT_MASK: rdata_nxt = {2'h0, evt_mask_r};
      default: rdata_nxt = `RST_BYTE;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= `RST_BYTE;
    end else if (rd_en) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= `RST_BYTE;
    end
  end

  // Checks on the bank's own behaviour
  property p_global_gate;
    @(posedge clk_sys) disable iff (rst)
    !global_irq_en_r |-> !core_irq_req;
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("Request without global enable"); // RQ14

  property p_periph_gate;
    @(posedge clk_sys) disable iff (rst)
    (!periph_group_irq_en_r && !low_req) |-> !core_irq_req;
  endproperty
  a_periph_gate: assert property (p_periph_gate) else $error("Upper request without group enable"); // RQ1

  property p_low_vector;
    @(posedge clk_sys) disable iff (rst)
    (global_irq_en_r && timer0_overflow_flag && timer0_irq_en) |-> core_irq_req;
  endproperty
  a_low_vector: assert property (p_low_vector) else $error("Timer0 request blocked"); // RQ15

  property p_unimpl_zero;
    @(posedge clk_sys) disable iff (rst)
    hit(rd_en, addr, `OFS_TIMER_EN) |=> (rdata[7:2] == 6'h00);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("Unimplemented bits read nonzero"); // RQ2

  property p_reset_clear;
    @(posedge clk_sys)
    rst |=> (timer_irq_enable_r == `RST_BYTE && clock_adc_irq_flags == `RST_BYTE &&
             !timer0_overflow_flag && !ext_pin_flag && !global_irq_en_r);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("State not cleared by reset"); // RQ13

  property p_timer0_set;
    @(posedge clk_sys) disable iff (rst)
    timer0_overflow |=> timer0_overflow_flag [*2] or (timer0_overflow_flag ##1 $past(wr_core));
  endproperty
  a_timer0_set: assert property (p_timer0_set) else $error("Timer0 flag not held"); // RQ7

  property p_summary_read;
    @(posedge clk_sys) disable iff (rst)
    hit(rd_en, addr, `OFS_CORE_FLAGS) |=> (rdata[4] == $past(pin_change_summary_flag));
  endproperty
  a_summary_read: assert property (p_summary_read) else $error("Summary flag mismatch"); // RQ8

  property p_ext_edge;
    @(posedge clk_sys) disable iff (rst)
    (ext_pin_rising_sel && ext_pin_in && !ext_pin_prev_r) |=> ext_pin_flag;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("Pin edge missed"); // RQ9

  property p_osc_hold;
    @(posedge clk_sys) disable iff (rst)
    (osc_fail_flag && !wr_clk_adc) |=> osc_fail_flag;
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("Oscillator flag dropped"); // RQ10

  property p_sw_set;
    @(posedge clk_sys) disable iff (rst)
    (wr_clk_adc && wdata[`BIT_CONVERTER_FLAG]) |=> converter_done_flag;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("Software set ignored"); // RQ16

  property p_status_sticky;
    @(posedge clk_sys) disable iff (rst)
    converter_done |=> evt_status_r[4] ##1 (evt_status_r[4] || $past(rd_en));
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("Status bit lost"); // RQ12

  c_core_req: cover property (@(posedge clk_sys) disable iff (rst) $rose(core_irq_req));
  c_upper_req: cover property (@(posedge clk_sys) disable iff (rst) upper_req && core_irq_req);
  c_set_clear_tie: cover property (@(posedge clk_sys) disable iff (rst)
                                   wr_core && timer0_overflow && !wdata[5]);
  c_irq_out: cover property (@(posedge clk_sys) disable iff (rst) irq);

endmodule : periph_irq_bank

// ===== sticky_flag_cell.sv
// Purpose: One hardware-set, software-written interrupt flag
// Assumes: Synchronous active high reset, one clock
// Notes: A hardware set in the same cycle as a software clear wins
`timescale 1ns/1ps
module sticky_flag_cell (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hw_set,
  input wire logic sw_wr,
  input wire logic sw_val,
  output logic flag
);

  // Set has priority over a software clear; writing one also sets
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (hw_set) begin
      flag <= 1'b1;
    end else if (sw_wr) begin
      flag <= sw_val;
    end
  end

endmodule : sticky_flag_cell

// ===== tb_top.sv
// Purpose: Self-checking bench of the peripheral interrupt bank
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: Expected values come from a bench model of enables and flags
`timescale 1ns/1ps
`include "irq_bank_defines.svh"
module tb_top;
  logic clk_sys, rst, wr_en, rd_en, ext_pin_rising_sel;
  irq_bank_pkg::reg_addr_t addr;
  irq_bank_pkg::reg_byte_t wdata, rdata;
  irq_bank_pkg::reg_byte_t timer_flags_in, logic_cell_flags_in, capcomp_flags_in, misc_flags_in;
  logic timer0_overflow, ext_pin_in, osc_fail_event, clock_switch_ready, converter_done;
  logic [4:0] port_change_flags;
  logic timer0_irq_en, pin_change_irq_en, ext_pin_irq_en;
  logic osc_fail_irq_en, clock_switch_irq_en, converter_irq_en;
  logic core_irq_req, irq;
  logic [7:0] en [4];
  logic [7:0] cf, kf, ctrl, msk;
  logic [31:0] r;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  localparam logic [7:0] MSK [4] = '{`MASK_TIMER_EN, `MASK_LOGIC_CELL_EN, `MASK_CAPCOMP_EN,
    `MASK_MISC_EN};

  periph_irq_bank periph_irq_bank_i (.clk_sys, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .timer0_overflow, .port_change_flags, .ext_pin_in, .ext_pin_rising_sel, .osc_fail_event,
    .clock_switch_ready, .converter_done, .timer0_irq_en, .pin_change_irq_en, .ext_pin_irq_en,
    .osc_fail_irq_en, .clock_switch_irq_en, .converter_irq_en, .timer_flags_in,
    .logic_cell_flags_in, .capcomp_flags_in, .misc_flags_in, .core_irq_req, .irq);
  event_source_model event_source_model_i (.clk_sys, .timer0_overflow, .port_change_flags,
    .ext_pin_in, .osc_fail_event, .clock_switch_ready, .converter_done);

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Cycle ceiling cuts a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  // Write strobe for one cycle and mirror it in the model
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    #1;
    case (a)
      4'h0, 4'h1, 4'h2, 4'h3: en[a[1:0]] = d & MSK[a[1:0]];
      `OFS_CORE_FLAGS: cf = d & 8'h21;
      `OFS_CLOCK_ADC_FLAGS: kf = d & 8'hc1;
      `OFS_IRQ_CTRL: ctrl = d & 8'hc0;
      `OFS_EVT_MASK: msk = d & `MASK_EVT;
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input bit c);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    if (c) chk($sformatf("rdata %h", a), e, rdata);
  endtask : rd

  function automatic logic exp_req();
    logic lo, sec, up;
    lo = (timer0_irq_en & cf[5]) | (pin_change_irq_en & |port_change_flags)
      | (ext_pin_irq_en & cf[0]);
    sec = (osc_fail_irq_en & kf[7]) | (clock_switch_irq_en & kf[6]) | (converter_irq_en & kf[0]);
    up = |{timer_flags_in & en[0], logic_cell_flags_in & en[1], capcomp_flags_in & en[2],
      misc_flags_in & en[3]};
    return ctrl[7] & (lo | (ctrl[6] & (sec | up)));
  endfunction : exp_req

  task automatic clear_model();
    en = '{8'h00, 8'h00, 8'h00, 8'h00};
    {cf, kf, ctrl, msk} = 32'h0;
  endtask : clear_model

  task automatic pin_edge(input logic sel, input logic v);
    @(posedge clk_sys);
    ext_pin_rising_sel <= sel;
    event_source_model_i.pin(v);
    repeat (3) @(posedge clk_sys);
  endtask : pin_edge

  // Main sequence
  initial begin
    rst = 1'b1;
    {wr_en, rd_en, ext_pin_rising_sel} = 3'b001;
    addr = 4'h0;
    wdata = 8'h00;
    {timer_flags_in, logic_cell_flags_in, capcomp_flags_in, misc_flags_in} = 32'h0;
    {timer0_irq_en, pin_change_irq_en, ext_pin_irq_en} = 3'h0;
    {osc_fail_irq_en, clock_switch_irq_en, converter_irq_en} = 3'h0;
    clear_model();
    void'($urandom(32'hfbcd));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00, 1);
    for (int a = 0; a < 4; a++) begin
      wr(a[3:0], 8'hff);
      rd(a[3:0], MSK[a], 1);
    end
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00, 1);
    // Hardware-set flags stay until written
    event_source_model_i.pulse(4'hf);
    rd(`OFS_CORE_FLAGS, 8'h20, 1);
    rd(`OFS_CLOCK_ADC_FLAGS, 8'hc1, 1);
    rd(`OFS_CLOCK_ADC_FLAGS, 8'hc1, 1);
    wr(`OFS_CLOCK_ADC_FLAGS, 8'h00);
    rd(`OFS_CLOCK_ADC_FLAGS, 8'h00, 1);
    pin_edge(1'b1, 1'b1);
    rd(`OFS_CORE_FLAGS, 8'h21, 1);
    wr(`OFS_CORE_FLAGS, 8'h00);
    pin_edge(1'b0, 1'b0);
    rd(`OFS_CORE_FLAGS, 8'h01, 1);
    wr(`OFS_CORE_FLAGS, 8'h00);
    pin_edge(1'b0, 1'b1);
    rd(`OFS_CORE_FLAGS, 8'h00, 1);
    event_source_model_i.set_ports(5'h10);
    wr(`OFS_CORE_FLAGS, 8'h00);
    rd(`OFS_CORE_FLAGS, 8'h10, 1);
    event_source_model_i.set_ports(5'h00);
    rd(`OFS_CORE_FLAGS, 8'h00, 1);
    // Sticky status, mask and level output
    rd(`OFS_EVT_STATUS, 8'h1f, 1);
    rd(`OFS_EVT_STATUS, 8'h00, 1);
    wr(`OFS_EVT_MASK, 8'h10);
    event_source_model_i.pulse(4'h8);
    #1;
    kf = 8'h01;
    chk("irq", 8'h01, {7'h0, irq});
    wr(`OFS_EVT_MASK, 8'h0f);
    chk("irq", 8'h00, {7'h0, irq});
    wr(`OFS_EVT_MASK, 8'h10);
    chk("irq", 8'h01, {7'h0, irq});
    rd(`OFS_EVT_STATUS, 8'h10, 1);
    chk("irq", 8'h00, {7'h0, irq});
    wr(`OFS_EVT_MASK, 8'h00);
    // Rising core request from a lowest-register source lands in status bit 5
    @(posedge clk_sys);
    timer0_irq_en <= 1'b1;
    wr(`OFS_CORE_FLAGS, 8'h20);
    wr(`OFS_IRQ_CTRL, 8'h80);
    chk("core_irq_req", {7'h0, exp_req()}, {7'h0, core_irq_req});
    rd(`OFS_EVT_STATUS, 8'h20, 1);
    wr(`OFS_IRQ_CTRL, 8'h00);
    // Random enables, flags and gates against the request model
    for (int i = 0; i < 60; i++) begin
      wr(`OFS_IRQ_CTRL, $urandom);
      wr($urandom_range(3, 0), $urandom);
      wr(`OFS_CORE_FLAGS, $urandom);
      wr(`OFS_CLOCK_ADC_FLAGS, $urandom);
      event_source_model_i.set_ports($urandom);
      r = $urandom;
      timer_flags_in <= r[7:0];
      logic_cell_flags_in <= r[15:8];
      capcomp_flags_in <= r[23:16];
      misc_flags_in <= r[31:24];
      r = $urandom;
      {timer0_irq_en, pin_change_irq_en, ext_pin_irq_en} <= r[2:0];
      {osc_fail_irq_en, clock_switch_irq_en, converter_irq_en} <= r[5:3];
      @(posedge clk_sys);
      #1;
      chk("core_irq_req", {7'h0, exp_req()}, {7'h0, core_irq_req});
      rd(`OFS_CLOCK_ADC_FLAGS, kf, 1);
      rd(`OFS_CORE_FLAGS, cf | {3'h0, |port_change_flags, 4'h0}, 1);
    end
    // Reset in mid-run clears everything again
    event_source_model_i.set_ports(5'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    clear_model();
    #1;
    chk("core_irq_req", 8'h00, {7'h0, core_irq_req});
    for (int a = 0; a < 9; a++) rd(a[3:0], 8'h00, 1);
    summarize();
  end
endmodule : tb_top
